// file: srs_pkg.sv
// Purpose: shared constants for the service request status logic
// Assumes: 8-bit status byte, three request conditions
// Notes: the bit constants are the bit positions in the status byte, not their weights
package srs_pkg;
  // ==========================================================
  // Status byte layout
  localparam int unsigned SRS_NUM_COND = 3;
  localparam int unsigned SRS_BIT_DATA_READY = 0;
  localparam int unsigned SRS_BIT_CODE_ERROR = 1;
  localparam int unsigned SRS_BIT_INST_ERROR = 2;
  localparam int unsigned SRS_BIT_SUMMARY = 6;
  localparam logic [7:0] SRS_BYTE_RESET = 8'h00;
  localparam logic [2:0] SRS_COND_NONE = 3'h0;
  // ==========================================================
  // Enable mask
  localparam logic [2:0] SRS_MASK_DISABLED = 3'h2;
  localparam logic [2:0] SRS_MASK_FORCED = 3'h2;
  localparam logic [7:0] SRS_SUFFIX_FIELD = 8'h07;
endpackage : srs_pkg

// file: srs_cond_bit.sv
// Purpose: one sticky condition bit of the status byte
// Assumes: set and clear are synchronous to clk_in
// Notes: a set in the clearing cycle is kept
`timescale 1ns/10ps
`default_nettype none
module srs_cond_bit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Control
  input wire logic set_in,
  input wire logic clear_in,
  // State
  output logic flag_out
);
  typedef struct packed {
    logic flag;
  } srs_bit_state_type;

  srs_bit_state_type state;
  srs_bit_state_type next_state;

  // ==========================================================
  // Sticky flag
  always_comb begin
    next_state = state;
    if (clear_in) begin
      next_state.flag = 1'b0;
    end
    // Set beats clear so no event is lost
    if (set_in) begin
      next_state.flag = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign flag_out = state.flag;
endmodule : srs_cond_bit
`default_nettype wire

// file: srs_service_request.sv
// Purpose: status byte and service request line of the instrument
// Assumes: condition events are one-cycle pulses on clk_in
// Notes: serial poll returns the byte, then clears it
`timescale 1ns/10ps
`default_nettype none
module srs_service_request
  import srs_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Condition events
  input wire logic data_ready_in,
  input wire logic code_error_in,
  input wire logic inst_error_in,
  // Mask load from the special function entry
  input wire logic mask_load_in,
  input wire logic [7:0] mask_suffix_in,
  // Clear actions; automatic operation input is unused
  input wire logic clear_message_in,
  input wire logic controller_reset_in,
  input wire logic automatic_operation_in,
  // Serial poll
  input wire logic serial_poll_in,
  output logic [7:0] status_byte_out,
  output logic status_valid_out,
  // Bus request and indicator
  output logic srq_out,
  output logic special_function_key_lamp_out,
  output logic [2:0] enable_mask_out
);
  typedef struct packed {
    logic [2:0] mask;
    logic [7:0] poll_byte;
    logic poll_valid;
  } srs_state_type;

  srs_state_type state;
  srs_state_type next_state;

  logic [SRS_NUM_COND-1:0] events;
  logic [SRS_NUM_COND-1:0] flags;
  logic [SRS_NUM_COND-1:0] sets;
  logic clear_all;
  logic [7:0] byte_now;

  // ==========================================================
  // Condition bits
  assign events = {inst_error_in, code_error_in, data_ready_in};
  // Automatic operation is not a clear source
  assign clear_all = serial_poll_in | clear_message_in |
                     controller_reset_in;
  assign sets = events & state.mask;

  genvar g;
  generate
    for (g = 0; g < SRS_NUM_COND; g++) begin : gen_cond
      srs_cond_bit u_bit (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .set_in(sets[g]),
        .clear_in(clear_all),
        .flag_out(flags[g])
      );
    end
  endgenerate

  // ==========================================================
  // Status byte assembly
  always_comb begin
    byte_now = SRS_BYTE_RESET;
    byte_now[SRS_BIT_DATA_READY] = flags[SRS_BIT_DATA_READY];
    byte_now[SRS_BIT_CODE_ERROR] = flags[SRS_BIT_CODE_ERROR];
    byte_now[SRS_BIT_INST_ERROR] = flags[SRS_BIT_INST_ERROR];
    byte_now[SRS_BIT_SUMMARY] = |flags;
  end

  // ==========================================================
  // Mask and poll capture
  always_comb begin
    next_state = state;
    next_state.poll_valid = 1'b0;
    if (mask_load_in) begin
      next_state.mask = (mask_suffix_in[2:0] & SRS_SUFFIX_FIELD[2:0]) |
                        SRS_MASK_FORCED;
    end
    // Clear actions win over a load in the same cycle
    if (clear_message_in | controller_reset_in) begin
      next_state.mask = SRS_MASK_DISABLED;
    end
    if (serial_poll_in) begin
      next_state.poll_byte = byte_now;
      next_state.poll_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state.mask <= SRS_MASK_DISABLED;
      state.poll_byte <= SRS_BYTE_RESET;
      state.poll_valid <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================
  // Outputs
  assign status_byte_out = state.poll_byte;
  assign status_valid_out = state.poll_valid;
  assign srq_out = |flags;
  // No lamp path from the mask logic
  assign special_function_key_lamp_out = 1'b0;
  assign enable_mask_out = state.mask;
endmodule : srs_service_request
`default_nettype wire

// file: srs_poll_model.sv
// Purpose: bus controller issuing serial polls
// Assumes: poll requests come from the bench
// Notes: poll lags its request by one cycle
`timescale 1ns/10ps
`default_nettype none
module srs_poll_model (
  // Clock and poll
  input wire logic clk_in,
  input wire logic poll_req_in,
  output logic serial_poll_out
);
  always_ff @(posedge clk_in) serial_poll_out <= poll_req_in;
endmodule : srs_poll_model
`default_nettype wire

// file: srs_chk.sv
// Purpose: port checks
// Assumes: one clock, sync reset
// Notes: bind at foot
`timescale 1ns/10ps
`default_nettype none
module srs_chk (
  // Watched ports
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic code_error_in,
  input wire logic clear_message_in,
  input wire logic serial_poll_in,
  input wire logic [7:0] status_byte_out,
  input wire logic status_valid_out,
  input wire logic srq_out,
  input wire logic special_function_key_lamp_out,
  input wire logic [2:0] enable_mask_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence code_s; code_error_in ##1 srq_out; endsequence
  sequence poll_s; serial_poll_in ##1 status_valid_out; endsequence
  code_req_a: assert property (code_error_in |-> code_s)
    else $error("no srq");
  poll_ans_a: assert property (serial_poll_in |-> poll_s)
    else $error("no valid");
  valid_src_a: assert property (status_valid_out |-> $past(serial_poll_in))
    else $error("stray valid");
  zero_bits_a: assert property ((status_byte_out & 8'hB8) == 8'h00)
    else $error("spare bit set");
  sum_bit_a: assert property (status_byte_out[6] == |status_byte_out[2:0])
    else $error("bad summary");
  mask_on_a: assert property (enable_mask_out[1])
    else $error("code mask off");
  mask_clr_a: assert property (clear_message_in |=> enable_mask_out == 3'h2)
    else $error("mask kept");
  lamp_off_a: assert property (!special_function_key_lamp_out)
    else $error("lamp on");
endmodule : srs_chk
bind srs_service_request srs_chk u_chk (.*);
`default_nettype wire

// file: srs_service_request_test.sv
// Purpose: test of the status logic
// Assumes: polls reach the device a cycle late
// Notes: scoreboard mirrors the device
`timescale 1ns/10ps
`default_nettype none
module srs_service_request_test;
  import srs_pkg::*;
  logic clk_in = 0, reset_in = 1, pr = 0, ld = 0, cm = 0, cr = 0, au = 0;
  logic poll, valid, srq, lamp, vd = 0;
  logic [2:0] ev = '0, fl = '0, mk = 3'h2, mask;
  logic [7:0] suf = '0, cap = '0, sb;
  logic [15:0] cs [5] = '{16'h0002, 16'h0070, 16'h0000, 16'hF840, 16'h0001};
  int seed = 7, bad_count = 0, n_compared = 0;
  always #20 clk_in = ~clk_in;
  srs_poll_model pm (.clk_in(clk_in), .poll_req_in(pr),
    .serial_poll_out(poll));
  srs_service_request dut (.clk_in(clk_in), .reset_in(reset_in),
    .data_ready_in(ev[0]), .code_error_in(ev[1]), .inst_error_in(ev[2]),
    .mask_load_in(ld), .mask_suffix_in(suf), .clear_message_in(cm),
    .controller_reset_in(cr), .automatic_operation_in(au),
    .serial_poll_in(poll), .status_byte_out(sb), .status_valid_out(valid),
    .srq_out(srq), .special_function_key_lamp_out(lamp),
    .enable_mask_out(mask));
  always @(posedge clk_in) if (reset_in) begin
    fl <= '0;
    mk <= SRS_MASK_DISABLED;
    cap <= '0;
    vd <= 1'b0;
  end else begin
    vd <= poll;
    fl <= fl & ~{3{poll | cm | cr}} | ev & mk;
    mk <= cm | cr ? SRS_MASK_DISABLED : ld ? suf[2:0] | SRS_MASK_FORCED : mk;
    if (poll) cap <= {1'b0, |fl, 3'h0, fl};
  end
  task chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  always @(negedge clk_in) if (!reset_in) begin
    chk("srq", {7'h0, srq}, {7'h0, |fl});
    chk("mask", {5'h0, mask}, {5'h0, mk});
    chk("byte", sb, cap);
    chk("valid", {7'h0, valid}, {7'h0, vd});
    chk("lamp", {7'h0, lamp}, 8'h00);
  end
  // Loads never share a cycle with events, so mask timing stays unambiguous
  task drive(logic [15:0] v);
    @(posedge clk_in);
    #1 ev = v[6] ? '0 : v[2:0];
    ld = v[6:4] == 3'h4;
    cm = v[6:4] == 3'h5;
    cr = v[6:4] == 3'h6;
    pr = v[6:4] == 3'h7;
    suf = v[15:8];
    au = v[7];
  endtask : drive
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    bad_count++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk_in);
    #1 reset_in = 0;
    foreach (cs[i]) drive(cs[i]);
    $display("test corners done");
    repeat (2) begin
      repeat (1500) drive(16'($random(seed)));
      #1 reset_in = 1;
      repeat (2) @(posedge clk_in);
      #1 reset_in = 0;
      $display("test random done");
    end
    wrap_up;
  end
endmodule : srs_service_request_test
`default_nettype wire
